// ===== hdl/fbic_flash_boot_image_control.sv
// Flash boot image control: serial flash access, settings store and image selection
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module fbic_flash_boot_image_control
   import fbic_pkg::*;
#(
   parameter int          SPI_DIV            = 2,
   parameter bit          RO_PROTECT         = 1'b0,
   parameter logic [31:0] DEFAULT_IP         = 32'h0A000001,
   parameter logic [31:0] STATION_ID_DEFAULT = 32'h00001234  // Arbitrary value
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [FBIC_ADDR_W-1:0] address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [31:0]            writedata,
   output logic      [31:0]            readdata,
   output logic                        waitrequest,
   output fbic_spi_out_type            spi_out,
   input  wire logic                   flash_miso,
   input  wire logic                   recovery_button,
   input  wire logic                   running_boot_loader,
   output fbic_boot_type               warm_boot,
   output logic      [31:0]            ip_address_setting,
   output logic                        startup_image_select,
   output logic      [31:0]            hw_station_id,
   output logic                        recovery_mode
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   fbic_state_type state_ff;
   fbic_job_type   job_ff;
   logic [2:0]     idx_ff;
   logic           sent_ff;
   logic           init_ff;
   logic           bus_job_ff;
   logic           resp_ff;
   logic           refused_ff;
   logic           loaded_ff;
   logic [31:0]    readdata_ff;
   logic [23:0]    pointer_ff;
   logic [31:0]    ip_edit_ff;
   logic           sel_edit_ff;
   logic [31:0]    ip_active_ff;
   logic           sel_active_ff;
   logic [31:0]    station_ff;
   logic           recovery_ff;
   fbic_boot_type  boot_ff;
   logic [15:0]    div_ff;
   logic           tick;
   logic           run_ff;
   logic           sclk_ff;
   logic [5:0]     cnt_ff;
   logic [39:0]    tx_ff;
   logic [7:0]     rx_ff;
   logic           frame_go;
   logic           frame_done;
   logic [5:0]     frame_bits;
   logic [39:0]    frame_tx;
   logic [23:0]    job_addr;
   logic [7:0]     job_byte;
   logic           req;
   logic           flash_req;
   logic           bus_start;
   logic           refuse;
   logic           accept;
   logic           job_end;
   fbic_job_type   bus_job;

   // Settings byte layout: byte 0 startup select, bytes 1..4 address big endian
   function automatic logic [7:0] setting_byte(input logic [2:0] i, input logic s,
                                               input logic [31:0] ip);
      logic [7:0] b;
      b = 8'h00;
      unique case (i)
         3'h0: b = {7'h00, s};
         3'h1: b = ip[31:24];
         3'h2: b = ip[23:16];
         3'h3: b = ip[15:8];
         default: b = ip[7:0];
      endcase
      return b;
   endfunction

   function automatic logic is_write_job(input fbic_job_type j);
      return (j == JOB_PROG) || (j == JOB_ERASE) || (j == JOB_SAVE_ERASE)
             || (j == JOB_SAVE_PROG);
   endfunction

   // ------------------------------------------------------------
   // Avalon request decode
   // ------------------------------------------------------------
   assign req         = read | write;
   assign waitrequest = req & ~resp_ff;
   assign accept      = req & resp_ff;
   assign flash_req   = req & ((address == FBIC_REG_DATA)
                        | (write & (address == FBIC_REG_WIPE))
                        | (write & (address == FBIC_REG_SAVE) & writedata[0])
                        | (write & (address == FBIC_REG_RESTART) & writedata[0]));

   always_comb begin
      bus_job = JOB_READ;
      if (address == FBIC_REG_DATA && write) begin
         bus_job = JOB_PROG;
      end else if (address == FBIC_REG_WIPE) begin
         bus_job = JOB_ERASE;
      end else if (address == FBIC_REG_SAVE) begin
         bus_job = JOB_SAVE_ERASE;
      end else if (address == FBIC_REG_RESTART) begin
         bus_job = JOB_CHECK;
      end
   end

   // Protection only when built in; factory and code regions sit below settings
   assign refuse    = RO_PROTECT && (bus_job == JOB_PROG || bus_job == JOB_ERASE)
                      && (pointer_ff < FBIC_SETTINGS_REGION);
   // A flash access starts only from idle, so a running erase or program holds it off
   assign bus_start = flash_req & ~resp_ff & ~bus_job_ff & ~init_ff
                      & (state_ff == ST_IDLE);
   assign job_end   = (state_ff == ST_NEXT) && !(job_ff == JOB_SAVE_ERASE)
                      && !(job_ff == JOB_SAVE_PROG && idx_ff != FBIC_LAST_SETTING)
                      && !(job_ff == JOB_LOAD && idx_ff != FBIC_LAST_SETTING)
                      && !(job_ff == JOB_LOAD && sel_edit_ff && !recovery_ff);

   // ------------------------------------------------------------
   // SPI bit engine
   // ------------------------------------------------------------
   assign tick = (div_ff == 16'(SPI_DIV - 1));

   always_ff @(posedge clk) begin
      if (reset || tick) begin
         div_ff <= 16'h0000;
      end else begin
         div_ff <= div_ff + 16'h0001;
      end
   end

   always_comb begin
      job_addr = pointer_ff;
      job_byte = writedata[7:0];
      if (job_ff == JOB_SAVE_PROG || job_ff == JOB_LOAD) begin
         job_addr = FBIC_SETTINGS_REGION + {21'h000000, idx_ff};
         job_byte = setting_byte(idx_ff, sel_edit_ff, ip_edit_ff);
      end else if (job_ff == JOB_SAVE_ERASE) begin
         job_addr = FBIC_SETTINGS_REGION;
      end else if (job_ff == JOB_CHECK) begin
         job_addr = FBIC_ALTERNATE_IMAGE_REGION;
      end
      frame_bits = FBIC_BITS_XFER;
      frame_tx   = {FBIC_OPC_READ, job_addr, 8'h00};
      if (state_ff == ST_WREN) begin
         frame_bits = FBIC_BITS_CMD;
         frame_tx   = {FBIC_OPC_WREN, 32'h00000000};
      end else if (state_ff == ST_POLL) begin
         frame_bits = FBIC_BITS_POLL;
         frame_tx   = {FBIC_OPC_RDSR, 32'h00000000};
      end else if (job_ff == JOB_ERASE || job_ff == JOB_SAVE_ERASE) begin
         frame_bits = FBIC_BITS_ERASE;
         frame_tx   = {FBIC_OPC_ERASE, job_addr, 8'h00};
      end else if (job_ff == JOB_PROG || job_ff == JOB_SAVE_PROG) begin
         frame_tx   = {FBIC_OPC_PROG, job_addr, job_byte};
      end
   end

   assign frame_go   = (state_ff == ST_WREN || state_ff == ST_MAIN || state_ff == ST_POLL)
                       && !run_ff && !sent_ff;
   assign frame_done = run_ff && tick && sclk_ff && (cnt_ff == 6'h01);

   // Mode 0: data changes on the falling edge, sampled on the rising edge
   always_ff @(posedge clk) begin
      if (reset) begin
         run_ff  <= 1'b0;
         sclk_ff <= 1'b0;
         cnt_ff  <= 6'h00;
         tx_ff   <= 40'h0000000000;
         rx_ff   <= 8'h00;
      end else if (frame_go) begin
         run_ff <= 1'b1;
         cnt_ff <= frame_bits;
         tx_ff  <= frame_tx;
      end else if (run_ff && tick) begin
         if (!sclk_ff) begin
            sclk_ff <= 1'b1;
            rx_ff   <= {rx_ff[6:0], flash_miso};
         end else begin
            sclk_ff <= 1'b0;
            tx_ff   <= {tx_ff[38:0], 1'b0};
            cnt_ff  <= cnt_ff - 6'h01;
            run_ff  <= (cnt_ff != 6'h01);
         end
      end
   end

   assign spi_out = '{sclk: sclk_ff, cs_n: ~run_ff, mosi: tx_ff[39]};

   // ------------------------------------------------------------
   // Job sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         job_ff   <= JOB_READ;
         idx_ff   <= 3'h0;
         sent_ff  <= 1'b0;
      end else begin
         if (frame_go) begin
            sent_ff <= 1'b1;
         end else if (frame_done) begin
            sent_ff <= 1'b0;
         end
         unique case (state_ff)
            ST_IDLE: begin
               if (init_ff && !recovery_button) begin
                  job_ff   <= JOB_LOAD;
                  idx_ff   <= 3'h0;
                  state_ff <= ST_MAIN;
               end else if (bus_start && !refuse) begin
                  job_ff   <= bus_job;
                  state_ff <= is_write_job(bus_job) ? ST_WREN : ST_MAIN;
               end
            end
            ST_WREN: begin
               if (frame_done) begin
                  state_ff <= ST_MAIN;
               end
            end
            ST_MAIN: begin
               if (frame_done) begin
                  state_ff <= is_write_job(job_ff) ? ST_POLL : ST_NEXT;
               end
            end
            ST_POLL: begin
               // Busy flag in flash keeps the sequencer polling
               if (frame_done && !rx_ff[FBIC_WIP_BIT]) begin
                  state_ff <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (job_end) begin
                  state_ff <= ST_IDLE;
               end else if (job_ff == JOB_SAVE_ERASE) begin
                  job_ff   <= JOB_SAVE_PROG;
                  idx_ff   <= 3'h0;
                  state_ff <= ST_WREN;
               end else if (job_ff == JOB_SAVE_PROG) begin
                  idx_ff   <= idx_ff + 3'h1;
                  state_ff <= ST_WREN;
               end else if (idx_ff == FBIC_LAST_SETTING) begin
                  job_ff   <= JOB_CHECK;
                  state_ff <= ST_MAIN;
               end else begin
                  idx_ff   <= idx_ff + 3'h1;
                  state_ff <= ST_MAIN;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Recovery strap is caught on the first clocked cycle after reset release
   always_ff @(posedge clk) begin
      if (reset) begin
         init_ff     <= 1'b1;
         recovery_ff <= 1'b0;
      end else if (init_ff && state_ff == ST_IDLE) begin
         init_ff     <= 1'b0;
         recovery_ff <= recovery_button;
      end
   end

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         resp_ff    <= 1'b0;
         bus_job_ff <= 1'b0;
         refused_ff <= 1'b0;
      end else begin
         resp_ff <= 1'b0;
         if (bus_start) begin
            bus_job_ff <= ~refuse;
            resp_ff    <= refuse;
            refused_ff <= refuse;
         end else if (req && !flash_req && !resp_ff) begin
            resp_ff <= 1'b1;
         end else if (bus_job_ff && job_end) begin
            bus_job_ff <= 1'b0;
            resp_ff    <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_ff <= 32'h00000000;
      end else if (!resp_ff) begin
         unique case (address)
            FBIC_REG_POINTER: readdata_ff <= {8'h00, pointer_ff};
            FBIC_REG_DATA:    readdata_ff <= {24'h000000, rx_ff};
            FBIC_REG_STARTUP: readdata_ff <= {31'h00000000, sel_edit_ff};
            FBIC_REG_IP:      readdata_ff <= ip_edit_ff;
            FBIC_REG_STATION: readdata_ff <= station_ff;
            FBIC_REG_STATUS:  readdata_ff <= {27'h0000000, loaded_ff, sel_active_ff,
                                              recovery_ff, refused_ff,
                                              (state_ff != ST_IDLE)};
            default:          readdata_ff <= 32'h00000000;
         endcase
      end
   end

   assign readdata = readdata_ff;

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         pointer_ff <= FBIC_FACTORY_IMAGE_REGION;
      end else if (accept && write && address == FBIC_REG_POINTER) begin
         pointer_ff <= writedata[23:0];
      end else if (accept && address == FBIC_REG_DATA && !refused_ff) begin
         pointer_ff <= pointer_ff + 24'h000001;
      end
   end

   // Editable settings; the active copies change only by a load after reset
   always_ff @(posedge clk) begin
      if (reset) begin
         ip_edit_ff  <= DEFAULT_IP;
         sel_edit_ff <= FBIC_IMAGE_LOADER;
      end else if (state_ff == ST_NEXT && job_ff == JOB_LOAD) begin
         if (idx_ff == 3'h0) begin
            sel_edit_ff <= (rx_ff == FBIC_SEL_DEPLOY);
         end else begin
            ip_edit_ff <= {ip_edit_ff[23:0], rx_ff};
         end
      end else if (accept && write && address == FBIC_REG_IP) begin
         ip_edit_ff <= writedata;
      end else if (accept && write && address == FBIC_REG_STARTUP) begin
         sel_edit_ff <= writedata[0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ip_active_ff  <= DEFAULT_IP;
         sel_active_ff <= FBIC_IMAGE_LOADER;
         loaded_ff     <= 1'b0;
      end else if (state_ff == ST_NEXT && job_ff == JOB_LOAD
                   && idx_ff == FBIC_LAST_SETTING) begin
         ip_active_ff  <= {ip_edit_ff[23:0], rx_ff};
         sel_active_ff <= sel_edit_ff;
         loaded_ff     <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         station_ff <= STATION_ID_DEFAULT;
      end else if (accept && write && address == FBIC_REG_STATION
                   && !running_boot_loader) begin
         station_ff <= writedata;
      end
   end

   // ------------------------------------------------------------
   // Warm boot request
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         boot_ff <= '{req: 1'b0, addr: FBIC_FACTORY_IMAGE_REGION};
      end else begin
         boot_ff.req <= 1'b0;
         if (state_ff == ST_NEXT && job_ff == JOB_CHECK) begin
            boot_ff.req  <= 1'b1;
            boot_ff.addr <= (rx_ff == FBIC_ERASED_BYTE) ? FBIC_FACTORY_IMAGE_REGION
                            : FBIC_ALTERNATE_IMAGE_REGION;
         end else if (accept && write && address == FBIC_REG_RESTART && !writedata[0]) begin
            boot_ff.req  <= 1'b1;
            boot_ff.addr <= FBIC_FACTORY_IMAGE_REGION;
         end
      end
   end

   assign warm_boot            = boot_ff;
   assign ip_address_setting   = ip_active_ff;
   assign startup_image_select = sel_active_ff;
   assign hw_station_id        = station_ff;
   assign recovery_mode        = recovery_ff;

endmodule // fbic_flash_boot_image_control

// ===== hdl/fbic_pkg.sv
// Package for the flash boot image control block: map, opcodes, encodings, carriers
package fbic_pkg;

   // ------------------------------------------------------------
   // Flash layout
   // ------------------------------------------------------------
   localparam logic [23:0] FBIC_FACTORY_IMAGE_REGION  = 24'h000000;
   localparam logic [23:0] FBIC_PROGRAM_CODE_REGION   = 24'h054000;
   localparam logic [23:0] FBIC_SETTINGS_REGION       = 24'h0C0000;
   localparam logic [23:0] FBIC_ALTERNATE_IMAGE_REGION = 24'h0D0000;

   // ------------------------------------------------------------
   // Register byte offsets on the Avalon slave
   // ------------------------------------------------------------
   localparam int          FBIC_ADDR_W      = 6;
   localparam logic [5:0]  FBIC_REG_POINTER = 6'h00;
   localparam logic [5:0]  FBIC_REG_DATA    = 6'h04;
   localparam logic [5:0]  FBIC_REG_WIPE    = 6'h08;
   localparam logic [5:0]  FBIC_REG_SAVE    = 6'h0C;
   localparam logic [5:0]  FBIC_REG_RESTART = 6'h10;
   localparam logic [5:0]  FBIC_REG_STARTUP = 6'h14;
   localparam logic [5:0]  FBIC_REG_IP      = 6'h18;
   localparam logic [5:0]  FBIC_REG_STATION = 6'h1C;
   localparam logic [5:0]  FBIC_REG_STATUS  = 6'h20;

   // ------------------------------------------------------------
   // Status register bits
   // ------------------------------------------------------------
   localparam int FBIC_STAT_BUSY     = 0;
   localparam int FBIC_STAT_REFUSED  = 1;
   localparam int FBIC_STAT_RECOVERY = 2;
   localparam int FBIC_STAT_ACTIVE   = 3;
   localparam int FBIC_STAT_LOADED   = 4;

   // ------------------------------------------------------------
   // Serial flash commands and frame lengths in bits
   // ------------------------------------------------------------
   localparam logic [7:0] FBIC_OPC_WREN  = 8'h06;
   localparam logic [7:0] FBIC_OPC_RDSR  = 8'h05;
   localparam logic [7:0] FBIC_OPC_READ  = 8'h03;
   localparam logic [7:0] FBIC_OPC_PROG  = 8'h02;
   localparam logic [7:0] FBIC_OPC_ERASE = 8'h20;
   localparam logic [5:0] FBIC_BITS_CMD   = 6'h08;
   localparam logic [5:0] FBIC_BITS_POLL  = 6'h10;
   localparam logic [5:0] FBIC_BITS_ERASE = 6'h20;
   localparam logic [5:0] FBIC_BITS_XFER  = 6'h28;
   localparam int         FBIC_WIP_BIT    = 0;
   localparam logic [7:0] FBIC_ERASED_BYTE = 8'hFF;
   localparam logic [7:0] FBIC_SEL_DEPLOY  = 8'h01;
   localparam logic [2:0] FBIC_LAST_SETTING = 3'h4;

   // ------------------------------------------------------------
   // Encodings and carriers
   // ------------------------------------------------------------
   localparam logic FBIC_IMAGE_LOADER = 1'b0;
   localparam logic FBIC_IMAGE_DEPLOY = 1'b1;

   typedef enum logic [2:0] {
      JOB_READ       = 3'b000,
      JOB_PROG       = 3'b001,
      JOB_ERASE      = 3'b010,
      JOB_SAVE_ERASE = 3'b011,
      JOB_SAVE_PROG  = 3'b100,
      JOB_LOAD       = 3'b101,
      JOB_CHECK      = 3'b110
   } fbic_job_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WREN = 3'b001,
      ST_MAIN = 3'b010,
      ST_POLL = 3'b011,
      ST_NEXT = 3'b100
   } fbic_state_type;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } fbic_spi_out_type;

   typedef struct packed {
      logic        req;
      logic [23:0] addr;
   } fbic_boot_type;

endpackage

// ===== tb/fbic_flash_boot_image_control_monitor.sv
// Port checker for the flash boot image control block
`timescale 1ns/1ps
module fbic_flash_boot_image_control_monitor
   import fbic_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic [FBIC_ADDR_W-1:0] address,
   input wire logic                   write,
   input wire logic                   read,
   input wire logic [31:0]            writedata,
   input wire logic                   waitrequest,
   input wire fbic_spi_out_type       spi_out,
   input wire logic                   recovery_button,
   input wire logic                   running_boot_loader,
   input wire fbic_boot_type          warm_boot,
   input wire logic [31:0]            hw_station_id,
   input wire logic                   recovery_mode
);
   // ----
   // Checks
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_wipe_starts_frame: assert property ($rose(write) && address == FBIC_REG_WIPE |-> ##[1:6] !spi_out.cs_n)
      else $error("wipe started no flash frame");
   a_read_starts_frame: assert property ($rose(read) && address == FBIC_REG_DATA |-> ##[1:6] !spi_out.cs_n)
      else $error("data read started no flash frame");
   a_save_starts_frame: assert property ($rose(write) && address == FBIC_REG_SAVE && writedata[0] |-> ##[1:6] !spi_out.cs_n)
      else $error("save started no flash frame");
   a_hold_off_busy: assert property (write && address == FBIC_REG_WIPE && !spi_out.cs_n |-> waitrequest)
      else $error("wipe accepted while frame open");
   a_factory_boot: assert property (write && address == FBIC_REG_RESTART && !writedata[0] && !waitrequest |=> warm_boot.req && warm_boot.addr == FBIC_FACTORY_IMAGE_REGION)
      else $error("restart 0 gave no factory boot");
   a_alt_boot_pulse: assert property (write && address == FBIC_REG_RESTART && writedata[0] && !waitrequest |-> warm_boot.req)
      else $error("restart 1 gave no boot pulse");
   a_recovery_entry: assert property ($fell(reset) && recovery_button |-> ##[1:2] recovery_mode)
      else $error("recovery mode not entered");
   a_station_locked: assert property (running_boot_loader |=> $stable(hw_station_id))
      else $error("station id changed in boot loader");
endmodule // fbic_flash_boot_image_control_monitor

bind fbic_flash_boot_image_control fbic_flash_boot_image_control_monitor i_monitor (
   .clk(clk), .reset(reset), .address(address), .write(write), .read(read),
   .writedata(writedata), .waitrequest(waitrequest), .spi_out(spi_out),
   .recovery_button(recovery_button), .running_boot_loader(running_boot_loader),
   .warm_boot(warm_boot), .hw_station_id(hw_station_id), .recovery_mode(recovery_mode));

// ===== tb/fbic_flash_boot_image_control_tb.sv
// Testbench for the flash boot image control block
`timescale 1ns/1ps
module fbic_flash_boot_image_control_tb;
   import fbic_pkg::*;
   localparam logic [31:0] IP0 = 32'h0A000001;
   localparam logic [31:0] SID = 32'h0000ABCD; // Arbitrary value
   logic             clk = 1'h0, reset = 1'h1, read = 1'h0, write = 1'h0, btn = 1'h0;
   logic             boot_ld = 1'h1, waitrequest, miso, sel, rec;
   logic [5:0]       address = '0;
   logic [31:0]      writedata = '0, readdata, q, ip, sid;
   logic [31:0]      regions [2] = '{32'h00054000, 32'h000D0000};
   fbic_spi_out_type spi;
   fbic_boot_type    wb;
   logic [31:0]      boot_addr = 32'hFFFFFFFF;
   int               bad_count = 0, checked = 0;
   always #20 clk = ~clk;
   always @(negedge clk) if (wb.req === 1'h1) boot_addr <= {8'h00, wb.addr};
   fbic_flash_boot_image_control #(.DEFAULT_IP(IP0), .STATION_ID_DEFAULT(SID)) i_fbic_flash_boot_image_control (
      .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .spi_out(spi),
      .flash_miso(miso), .recovery_button(btn), .running_boot_loader(boot_ld), .warm_boot(wb),
      .ip_address_setting(ip), .startup_image_select(sel), .hw_station_id(sid), .recovery_mode(rec));
   fbic_flash_model i_fbic_flash_model (.clk(clk), .spi_out(spi), .flash_miso(miso));
   // ----
   // Tasks
   // ----
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   // Request held until the rising edge at which waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge clk);
         k++;
         if (k > 4000) begin
            bad_count++;
            summarize();
         end
      end while (waitrequest !== 1'h0);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic rst(input logic b);
      @(posedge clk);
      btn <= b;
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      repeat (2) @(posedge clk);
      btn <= 1'h0;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      rst(1'h0);
      bus(1'h0, FBIC_REG_DATA, '0);
      chk("ip loaded", 32'hC0A80009, ip);
      chk("select loaded", 32'h0, {31'h0, sel});
      bus(1'h1, FBIC_REG_RESTART, 32'h1);
      chk("fallback boot", 32'h0, boot_addr);
      foreach (regions[i]) begin
         bus(1'h1, FBIC_REG_POINTER, regions[i]);
         bus(1'h1, FBIC_REG_WIPE, 32'hFFFFFFFF);
         bus(1'h1, FBIC_REG_DATA, 32'h5A);
         bus(1'h1, FBIC_REG_DATA, 32'hC3);
         bus(1'h0, FBIC_REG_POINTER, '0);
         chk("pointer", regions[i] + 32'h2, q);
         bus(1'h1, FBIC_REG_POINTER, regions[i]);
         bus(1'h0, FBIC_REG_DATA, '0);
         chk("byte 0", 32'h5A, q & 32'hFF);
         bus(1'h0, FBIC_REG_DATA, '0);
         chk("byte 1", 32'hC3, q & 32'hFF);
      end
      bus(1'h1, FBIC_REG_RESTART, 32'h1);
      chk("alternate boot", 32'h000D0000, boot_addr);
      bus(1'h1, FBIC_REG_RESTART, 32'h0);
      chk("factory boot", 32'h0, boot_addr);
      bus(1'h1, FBIC_REG_STATION, 32'h11223344);
      chk("station locked", SID, sid);
      @(posedge clk);
      boot_ld <= 1'h0;
      bus(1'h1, FBIC_REG_STATION, 32'h11223344);
      chk("station", 32'h11223344, sid);
      bus(1'h1, FBIC_REG_IP, 32'h0A0B0C0D);
      bus(1'h1, FBIC_REG_STARTUP, 32'h1);
      bus(1'h1, FBIC_REG_SAVE, 32'h1);
      chk("ip before restart", 32'hC0A80009, ip);
      rst(1'h0);
      bus(1'h0, FBIC_REG_DATA, '0);
      chk("ip saved", 32'h0A0B0C0D, ip);
      chk("select saved", 32'h1, {31'h0, sel});
      chk("startup boot", 32'h000D0000, boot_addr);
      rst(1'h1);
      bus(1'h0, FBIC_REG_STATUS, '0);
      chk("status", 32'h4, q);
      chk("recovery", 32'h1, {31'h0, rec});
      chk("recovery ip", IP0, ip);
      chk("recovery select", 32'h0, {31'h0, sel});
      bus(1'h0, 6'h3C, '0);
      chk("unmapped", 32'h0, q);
      summarize();
   end
endmodule // fbic_flash_boot_image_control_tb

// ===== tb/fbic_flash_model.sv
// Behavioural serial flash facing the block
`timescale 1ns/1ps
module fbic_flash_model
   import fbic_pkg::*;
#(
   parameter int BUSY_CYC = 100
) (
   input  wire logic             clk,
   input  wire fbic_spi_out_type spi_out,
   output logic                  flash_miso
);
   logic [7:0]  mem [logic [23:0]];
   logic [7:0]  cfg [5] = '{8'h00, 8'hC0, 8'hA8, 8'h00, 8'h09};
   logic [39:0] sh = '0;
   logic [7:0]  cmd = '0;
   logic [7:0]  obyte = '0;
   logic [23:0] adr = '0;
   logic        wel = 1'h0;
   int          n = 0;
   int          busy = 0;
   function automatic logic [7:0] rd(input logic [23:0] a);
      return mem.exists(a) ? mem[a] : FBIC_ERASED_BYTE;
   endfunction
   // ----
   // Frames
   // ----
   initial begin
      flash_miso = 1'h0;
      mem[FBIC_PROGRAM_CODE_REGION] = 8'h00;
      for (int i = 0; i < 5; i++) mem[FBIC_SETTINGS_REGION + 24'(i)] = cfg[i];
   end
   always @(negedge spi_out.cs_n) n = 0;
   always @(posedge spi_out.sclk) if (!spi_out.cs_n) begin
      sh = {sh[38:0], spi_out.mosi};
      n++;
      if (n == 8) cmd = sh[7:0];
      if (n == 8) obyte = {7'h00, busy != 0};
      if (n == 32) adr = sh[23:0];
      if (n == 32) obyte = rd(sh[23:0]);
   end
   always @(negedge spi_out.sclk) if (!spi_out.cs_n) flash_miso <= obyte[7 - (n % 8)];
   // Released line drifts so a stale bit is never read as data
   always @(posedge clk) begin
      if (spi_out.cs_n) flash_miso <= ~flash_miso;
      if (busy != 0) busy--;
   end
   // No region is protected here
   always @(posedge spi_out.cs_n) begin
      if (cmd == FBIC_OPC_WREN && n == 8) wel = 1'h1;
      if (wel && cmd == FBIC_OPC_PROG && n == 40) begin
         mem[adr] = rd(adr) & sh[7:0];
         wel = 1'h0;
         busy = BUSY_CYC;
      end
      if (wel && cmd == FBIC_OPC_ERASE && n == 32) begin
         for (int i = 0; i < 4096; i++) mem.delete({adr[23:12], 12'h000} + 24'(i));
         wel = 1'h0;
         busy = BUSY_CYC;
      end
   end
endmodule // fbic_flash_model
